/* ccic_bus_model.sv */
// open-drain local bus with pull-ups and a master that can hold lines low
`timescale 1ns/1ps
`default_nettype none
module ccic_bus_model (
  // device side enables
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  // master pulls
  input wire logic mst_scl_low,
  input wire logic mst_sda_low,
  // resolved lines
  output logic scl,
  output logic sda
);
  // pull-ups: a released line reads high, never the last value
  assign scl = scl_oe_n & ~mst_scl_low;
  assign sda = sda_oe_n & ~mst_sda_low;
endmodule // ccic_bus_model
`default_nettype wire

/* ccic_ctrl.v */
// control channel bus configuration, status, remap and watchdog logic
`timescale 1ns/1ps
`default_nettype none
`include "ccic_map.vh"
module ccic_ctrl #(
  parameter [31:0] WD_LONG_CYC = `CCIC_WD_LONG_NS / `CCIC_CLK_NS,
  parameter [31:0] WD_SHORT_CYC = `CCIC_WD_SHORT_NS / `CCIC_CLK_NS,
  parameter [31:0] RCV_HALF_CYC = `CCIC_RCV_HALF_NS / `CCIC_CLK_NS
) (
  // clock and reset
  input wire REF_CLK,
  input wire RSTN,
  // register port of the serial control slave
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_REMOTE,
  input wire REG_RD,
  output reg [7:0] REG_RDATA,
  output reg REG_WR_REJECT,
  // forward control channel events
  input wire SEQ_ERR,
  input wire [6:0] REMOTE_SERIALIZER_ID_IN,
  input wire REMOTE_SERIALIZER_ID_VALID,
  // local transaction address remap
  input wire [6:0] TXN_ADDR,
  input wire TXN_VALID,
  output reg [6:0] FWD_ADDR,
  output reg FWD_HIT,
  output reg FWD_VALID,
  // local bus pins
  input wire SCL_I,
  input wire SDA_I,
  input wire SDA_DRV_LOW,
  output wire SCL_O,
  output wire SCL_OE_N,
  output wire SDA_O,
  output wire SDA_OE_N,
  output wire BUS_FREE
);
  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  // least delay, so the cycle count rounds up
  function [6:0] dly_cycles;
    input [1:0] code;
    reg [31:0] ns;
    begin
      ns = `CCIC_SDA_DLY_BASE_NS + `CCIC_SDA_DLY_STEP_NS * code;
      ns = (ns + `CCIC_CLK_NS - 1) / `CCIC_CLK_NS;
      dly_cycles = ns[6:0];
    end
  endfunction

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  reg seq_err_reg;
  reg seq_clr_reg;
  reg [1:0] sda_dly_reg;
  reg wr_blk_reg;
  reg wd_fast_reg;
  reg wd_off_reg;
  reg [6:0] rem_id_reg;
  reg freeze_reg;
  reg [6:0] tgt0_reg;
  reg [6:0] tgt1_reg;
  reg [6:0] alias0_reg;
  reg [6:0] alias1_reg;
  wire [7:0] ctrl2 = {seq_err_reg, seq_clr_reg, 1'b0, sda_dly_reg,
                      wr_blk_reg, wd_fast_reg, wd_off_reg};

  function is_wr;
    input [7:0] ofs;
    begin
      is_wr = REG_WR && (REG_ADDR == ofs) && !(REG_REMOTE && wr_blk_reg);
    end
  endfunction

  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      seq_err_reg <= 1'b0;
      seq_clr_reg <= 1'b0;
      sda_dly_reg <= 2'h0;
      wr_blk_reg <= 1'b0;
      wd_fast_reg <= 1'b0;
      wd_off_reg <= 1'b0;
      rem_id_reg <= `CCIC_RST_ADDR;
      freeze_reg <= 1'b0;
      tgt0_reg <= `CCIC_RST_ADDR;
      tgt1_reg <= `CCIC_RST_ADDR;
      alias0_reg <= `CCIC_RST_ADDR;
      alias1_reg <= `CCIC_RST_ADDR;
      REG_WR_REJECT <= 1'b0;
    end
    else
    begin
      REG_WR_REJECT <= REG_WR && REG_REMOTE && wr_blk_reg;
      if (is_wr(`CCIC_OFS_BUS_CTRL2))
      begin
        seq_clr_reg <= REG_WDATA[`CCIC_BIT_SEQ_CLR];
        sda_dly_reg <= REG_WDATA[`CCIC_BIT_DLY_HI:`CCIC_BIT_DLY_LO];
        wr_blk_reg <= REG_WDATA[`CCIC_BIT_WR_BLOCK];
        wd_fast_reg <= REG_WDATA[`CCIC_BIT_WD_FAST];
        wd_off_reg <= REG_WDATA[`CCIC_BIT_WD_OFF];
      end
      // a new error in a clearing cycle is kept
      if (SEQ_ERR)
        seq_err_reg <= 1'b1;
      else if (seq_clr_reg)
        seq_err_reg <= 1'b0;
      if (is_wr(`CCIC_OFS_REMOTE_SERIALIZER_ID))
      begin
        freeze_reg <= REG_WDATA[`CCIC_BIT_FREEZE];
        if (freeze_reg)
          rem_id_reg <= REG_WDATA[`CCIC_BIT_ADDR_HI:`CCIC_BIT_ADDR_LO];
      end
      else if (REMOTE_SERIALIZER_ID_VALID && !freeze_reg)
        rem_id_reg <= REMOTE_SERIALIZER_ID_IN;
      if (is_wr(`CCIC_OFS_TGT_ADDR0))
        tgt0_reg <= REG_WDATA[`CCIC_BIT_ADDR_HI:`CCIC_BIT_ADDR_LO];
      if (is_wr(`CCIC_OFS_TGT_ADDR1))
        tgt1_reg <= REG_WDATA[`CCIC_BIT_ADDR_HI:`CCIC_BIT_ADDR_LO];
      if (is_wr(`CCIC_OFS_ALIAS0))
        alias0_reg <= REG_WDATA[`CCIC_BIT_ADDR_HI:`CCIC_BIT_ADDR_LO];
      if (is_wr(`CCIC_OFS_ALIAS1))
        alias1_reg <= REG_WDATA[`CCIC_BIT_ADDR_HI:`CCIC_BIT_ADDR_LO];
    end
  end

  // ---------------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------------
  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      REG_RDATA <= `CCIC_RST_BYTE;
    else if (REG_RD)
    begin
      if (REG_ADDR == `CCIC_OFS_BUS_CTRL2)
        REG_RDATA <= ctrl2;
      else if (REG_ADDR == `CCIC_OFS_REMOTE_SERIALIZER_ID)
        REG_RDATA <= {rem_id_reg, freeze_reg};
      else if (REG_ADDR == `CCIC_OFS_TGT_ADDR0)
        REG_RDATA <= {tgt0_reg, 1'b0};
      else if (REG_ADDR == `CCIC_OFS_TGT_ADDR1)
        REG_RDATA <= {tgt1_reg, 1'b0};
      else if (REG_ADDR == `CCIC_OFS_ALIAS0)
        REG_RDATA <= {alias0_reg, 1'b0};
      else if (REG_ADDR == `CCIC_OFS_ALIAS1)
        REG_RDATA <= {alias1_reg, 1'b0};
      else
        REG_RDATA <= `CCIC_RST_BYTE;
    end
  end

  // ---------------------------------------------------------------------
  // address remap
  // ---------------------------------------------------------------------
  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      FWD_ADDR <= `CCIC_RST_ADDR;
      FWD_HIT <= 1'b0;
      FWD_VALID <= 1'b0;
    end
    else
    begin
      FWD_VALID <= TXN_VALID;
      if (TXN_VALID)
      begin
        // slot 0 wins if both aliases hold the same address
        if (TXN_ADDR == alias0_reg)
        begin
          FWD_ADDR <= tgt0_reg;
          FWD_HIT <= 1'b1;
        end
        else if (TXN_ADDR == alias1_reg)
        begin
          FWD_ADDR <= tgt1_reg;
          FWD_HIT <= 1'b1;
        end
        else
        begin
          FWD_ADDR <= TXN_ADDR;
          FWD_HIT <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  reg [2:0] scl_sync_reg;
  reg [2:0] sda_sync_reg;
  reg scl_lvl_reg;
  reg sda_lvl_reg;
  wire scl_next = (scl_sync_reg[1] == scl_sync_reg[2]) ?
                  scl_sync_reg[2] : scl_lvl_reg;
  wire sda_next = (sda_sync_reg[1] == sda_sync_reg[2]) ?
                  sda_sync_reg[2] : sda_lvl_reg;
  wire scl_fall = scl_lvl_reg && !scl_next;
  wire bus_act = (scl_next != scl_lvl_reg) || (sda_next != sda_lvl_reg);

  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_lvl_reg <= 1'b1;
      sda_lvl_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], SCL_I};
      sda_sync_reg <= {sda_sync_reg[1:0], SDA_I};
      scl_lvl_reg <= scl_next;
      sda_lvl_reg <= sda_next;
    end
  end

  // ---------------------------------------------------------------------
  // sda output delay after each scl fall
  // ---------------------------------------------------------------------
  reg [6:0] dly_cnt_reg;
  reg sda_low_reg;
  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      dly_cnt_reg <= 7'h0;
      sda_low_reg <= 1'b0;
    end
    else if (scl_fall)
      dly_cnt_reg <= dly_cycles(sda_dly_reg);
    else if (dly_cnt_reg != 7'h0)
    begin
      dly_cnt_reg <= dly_cnt_reg - 7'h1;
      if (dly_cnt_reg == 7'h1)
        sda_low_reg <= SDA_DRV_LOW;
    end
  end

  // ---------------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------------
  wire scl_low;
  wire recovering;
  ccic_wdog #(
    .WD_LONG_CYC(WD_LONG_CYC),
    .WD_SHORT_CYC(WD_SHORT_CYC),
    .RCV_HALF_CYC(RCV_HALF_CYC)
  ) u_wdog (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .wd_off(wd_off_reg),
    .wd_fast(wd_fast_reg),
    .sda_lvl(sda_lvl_reg),
    .bus_act(bus_act),
    .bus_free_reg(BUS_FREE),
    .scl_low_reg(scl_low),
    .recovering(recovering)
  );

  // open drain: only ever drive low; sda is released during recovery
  assign SCL_O = 1'b0;
  assign SCL_OE_N = ~scl_low;
  assign SDA_O = 1'b0;
  assign SDA_OE_N = ~(sda_low_reg && !recovering);
endmodule // ccic_ctrl
`default_nettype wire

/* ccic_ctrl_sva.sv */
// port assertions of the control channel configuration block
`timescale 1ns/1ps
`default_nettype none
module ccic_ctrl_sva #(
  parameter [31:0] RCV_HALF_CYC = 1250
) (
  // clock, reset, register port
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_REMOTE,
  input wire logic REG_WR_REJECT,
  // remap
  input wire logic [6:0] TXN_ADDR,
  input wire logic TXN_VALID,
  input wire logic [6:0] FWD_ADDR,
  input wire logic FWD_HIT,
  input wire logic FWD_VALID,
  // bus
  input wire logic SDA_I,
  input wire logic SCL_OE_N,
  input wire logic BUS_FREE
);
  // ---------------------------------------
  // shadow of block and watchdog-off bits
  // ---------------------------------------
  logic blk_reg, off_reg, off_d_reg;
  logic [31:0] low_reg;
  wire ok_wr = REG_WR && REG_ADDR == 8'h06 && !(REG_REMOTE && blk_reg);
  always @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      blk_reg <= 1'h0;
      off_reg <= 1'h0;
      off_d_reg <= 1'h0;
      low_reg <= 32'h0;
    end
    else
    begin
      if (ok_wr)
      begin
        blk_reg <= REG_WDATA[2];
        off_reg <= REG_WDATA[0];
      end
      off_d_reg <= off_reg;
      low_reg <= SCL_OE_N ? 32'h0 : low_reg + 32'h1;
    end
  default clocking dcb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);
  rej_remote_a: assert property (REG_WR && REG_REMOTE && blk_reg
    |=> REG_WR_REJECT) else $error("remote write not refused");
  rej_local_a: assert property (REG_WR && !(REG_REMOTE && blk_reg)
    |=> !REG_WR_REJECT) else $error("write wrongly refused");
  fwd_pulse_a: assert property (FWD_VALID == $past(TXN_VALID))
    else $error("forward valid not one cycle after request");
  fwd_miss_a: assert property (FWD_VALID && !FWD_HIT
    |-> FWD_ADDR == $past(TXN_ADDR)) else $error("miss address changed");
  free_high_a: assert property ($rose(BUS_FREE) |-> $past(SDA_I, 6))
    else $error("bus free with sda low");
  free_clear_a: assert property ($fell(SDA_I) && !off_reg
    |-> ##[1:8] !BUS_FREE) else $error("bus free kept after activity");
  rcv_width_a: assert property ($rose(SCL_OE_N) && !off_reg
    |-> low_reg == RCV_HALF_CYC) else $error("recovery pulse width");
  wd_off_a: assert property (off_d_reg
    |-> SCL_OE_N && !$rose(BUS_FREE)) else $error("watchdog acts while off");
  rej_c: cover property (REG_WR_REJECT);
  rcv_c: cover property ($rose(SCL_OE_N));
  free_c: cover property ($rose(BUS_FREE));
endmodule // ccic_ctrl_sva
bind ccic_ctrl ccic_ctrl_sva #(.RCV_HALF_CYC(RCV_HALF_CYC)) u_sva (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_REMOTE(REG_REMOTE),
  .REG_WR_REJECT(REG_WR_REJECT), .TXN_ADDR(TXN_ADDR),
  .TXN_VALID(TXN_VALID), .FWD_ADDR(FWD_ADDR), .FWD_HIT(FWD_HIT),
  .FWD_VALID(FWD_VALID), .SDA_I(SDA_I), .SCL_OE_N(SCL_OE_N),
  .BUS_FREE(BUS_FREE));
`default_nettype wire

/* ccic_ctrl_tb_top.sv */
// self-checking bench of the control channel configuration block
`timescale 1ns/1ps
`default_nettype none
module ccic_ctrl_tb_top;
  localparam int WL = 200;
  localparam int WS = 50;
  logic clk = 1'h0, rstn = 1'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic wr = 1'h0, rem = 1'h0, rd = 1'h0, seq = 1'h0, rvld = 1'h0;
  logic [6:0] rid = 7'h00, taddr = 7'h00;
  logic tvld = 1'h0, drv = 1'h0, mscl = 1'h0, msda = 1'h0, rj;
  wire [7:0] rdata;
  wire [6:0] faddr;
  wire rej, fhit, fvld, scl_oe_n, sda_oe_n, bus_free, scl, sda;
  wire scl_o, sda_o;
  int errors = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  ccic_ctrl #(.WD_LONG_CYC(WL), .WD_SHORT_CYC(WS), .RCV_HALF_CYC(4)) uut (
    .REF_CLK(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_REMOTE(rem), .REG_RD(rd), .REG_RDATA(rdata),
    .REG_WR_REJECT(rej), .SEQ_ERR(seq), .REMOTE_SERIALIZER_ID_IN(rid),
    .REMOTE_SERIALIZER_ID_VALID(rvld), .TXN_ADDR(taddr), .TXN_VALID(tvld),
    .FWD_ADDR(faddr), .FWD_HIT(fhit), .FWD_VALID(fvld), .SCL_I(scl),
    .SDA_I(sda), .SDA_DRV_LOW(drv), .SCL_O(scl_o), .SCL_OE_N(scl_oe_n),
    .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .BUS_FREE(bus_free));
  ccic_bus_model bus (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
    .mst_scl_low(mscl), .mst_sda_low(msda), .scl(scl), .sda(sda));
  // ---------------------------------------
  // shared tasks
  // ---------------------------------------
  task automatic chk(input string nm, input logic [7:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang(input int n, lim);
    if (n >= lim)
    begin
      errors++;
      give_verdict;
    end
  endtask
  task automatic wreg(input logic [7:0] a, d, input logic r);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    rem <= r;
    @(posedge clk);
    wr <= 1'h0;
    rem <= 1'h0;
    #1;
    rj = rej;
  endtask
  task automatic rreg(input logic [7:0] a, e, input string nm);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk(nm, rdata, e);
  endtask
  task automatic pulse(input logic s, input logic [6:0] v);
    @(posedge clk);
    seq <= s;
    rvld <= !s;
    rid <= v;
    @(posedge clk);
    seq <= 1'h0;
    rvld <= 1'h0;
  endtask
  task automatic send(input logic [6:0] a, e, input logic h);
    @(posedge clk);
    taddr <= a;
    tvld <= 1'h1;
    @(posedge clk);
    tvld <= 1'h0;
    #1;
    chk("fwd", {fvld, faddr}, {1'h1, e});
    chk("hit", {7'h00, fhit}, {7'h00, h});
  endtask
  // scl falls with the given sda request; n counts cycles to the output
  task automatic scl_fall(input logic d, output int n);
    @(posedge clk);
    mscl <= 1'h0;
    repeat (8) @(posedge clk);
    drv <= d;
    mscl <= 1'h1;
    for (n = 0; n < 200 && sda_oe_n !== !d; n++)
      @(negedge clk);
    hang(n, 200);
  endtask
  // ---------------------------------------
  // scenarios
  // ---------------------------------------
  task automatic t_regs;
    rreg(8'h06, 8'h00, "ctrl2");
    chk("od data", {6'h00, scl_o, sda_o}, 8'h00);
    rreg(8'h07, 8'h00, "rid");
    rreg(8'h08, 8'h00, "tgt0");
    rreg(8'h09, 8'h00, "tgt1");
    rreg(8'h10, 8'h00, "alias0");
    rreg(8'h20, 8'h00, "unmapped");
    wreg(8'h06, 8'h80, 1'h0);
    rreg(8'h06, 8'h00, "err ro");
    wreg(8'h07, 8'hA4, 1'h0);
    rreg(8'h07, 8'h00, "rid ro");
  endtask
  task automatic t_seq;
    pulse(1'h1, 7'h00);
    rreg(8'h06, 8'h80, "err set");
    wreg(8'h06, 8'h40, 1'h0);
    rreg(8'h06, 8'h40, "err clr");
    wreg(8'h06, 8'h00, 1'h0);
    pulse(1'h1, 7'h00);
    rreg(8'h06, 8'h80, "err again");
    wreg(8'h06, 8'h40, 1'h0);
    wreg(8'h06, 8'h00, 1'h0);
  endtask
  task automatic t_block;
    wreg(8'h06, 8'h04, 1'h0);
    wreg(8'h08, 8'hAA, 1'h1);
    chk("rej", {7'h00, rj}, 8'h01);
    rreg(8'h08, 8'h00, "blocked");
    wreg(8'h06, 8'h00, 1'h1);
    chk("rej ctl", {7'h00, rj}, 8'h01);
    wreg(8'h08, 8'hAA, 1'h0);
    chk("rej loc", {7'h00, rj}, 8'h00);
    rreg(8'h08, 8'hAA, "local");
    wreg(8'h06, 8'h00, 1'h0);
    wreg(8'h08, 8'h54, 1'h1);
    chk("rej off", {7'h00, rj}, 8'h00);
    rreg(8'h08, 8'h54, "remote");
  endtask
  task automatic t_rid;
    pulse(1'h0, 7'h35);
    rreg(8'h07, 8'h6A, "auto");
    wreg(8'h07, 8'h01, 1'h0);
    wreg(8'h07, 8'hA5, 1'h0);
    rreg(8'h07, 8'hA5, "frozen");
    pulse(1'h0, 7'h12);
    rreg(8'h07, 8'hA5, "held");
  endtask
  task automatic t_remap;
    wreg(8'h10, 8'h42, 1'h0);
    wreg(8'h11, 8'h66, 1'h0);
    wreg(8'h08, 8'hA0, 1'h0);
    wreg(8'h09, 8'h9E, 1'h0);
    send(7'h21, 7'h50, 1'h1);
    send(7'h33, 7'h4F, 1'h1);
    send(7'h15, 7'h15, 1'h0);
  endtask
  task automatic t_delay;
    int n, lo;
    for (int c = 0; c < 4; c++)
    begin
      wreg(8'h06, {3'h0, c[1:0], 3'h1}, 1'h0);
      scl_fall(1'h0, n);
      scl_fall(1'h1, n);
      lo = (250 + 50 * c + 3) / 4;
      chk("sda dly", {7'h00, n >= lo && n <= lo + 8}, 8'h01);
    end
    scl_fall(1'h0, n);
    @(posedge clk);
    mscl <= 1'h0;
  endtask
  task automatic wd_free(input logic [7:0] c, input int lo);
    int n;
    wreg(8'h06, c, 1'h0);
    @(posedge clk);
    msda <= 1'h1;
    repeat (8) @(posedge clk);
    msda <= 1'h0;
    for (n = 0; n < 600 && bus_free !== 1'h1; n++)
      @(negedge clk);
    hang(n, 600);
    chk("free", {7'h00, n >= lo && n <= lo + 12}, 8'h01);
  endtask
  task automatic wd_hung(input logic [7:0] c, exp);
    int k;
    logic p;
    wreg(8'h06, c, 1'h0);
    @(posedge clk);
    msda <= 1'h1;
    k = 0;
    p = 1'h1;
    repeat (160)
    begin
      @(negedge clk);
      if (scl_oe_n === 1'h0 && p === 1'h1)
        k++;
      p = scl_oe_n;
    end
    chk("scl pulses", k[7:0], exp);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    t_regs;
    t_seq;
    t_block;
    t_rid;
    t_remap;
    t_delay;
    wd_free(8'h00, WL);
    wd_free(8'h02, WS);
    wd_hung(8'h02, 8'h09);
    wd_hung(8'h01, 8'h00);
    @(posedge clk);
    msda <= 1'h0;
    repeat (300) @(posedge clk);
    chk("free off", {7'h00, bus_free}, 8'h00);
    give_verdict;
  end
endmodule // ccic_ctrl_tb_top
`default_nettype wire

/* ccic_map.vh */
// register map, field positions and timing constants of the control channel
`ifndef CCIC_MAP_VH
`define CCIC_MAP_VH
// -----------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------
`define CCIC_OFS_BUS_CTRL2 8'h06
`define CCIC_OFS_REMOTE_SERIALIZER_ID 8'h07
`define CCIC_OFS_TGT_ADDR0 8'h08
`define CCIC_OFS_TGT_ADDR1 8'h09
`define CCIC_OFS_ALIAS0 8'h10
`define CCIC_OFS_ALIAS1 8'h11
// -----------------------------------------------------------------------
// reset values and field positions
// -----------------------------------------------------------------------
`define CCIC_RST_BYTE 8'h00
`define CCIC_RST_ADDR 7'h00
`define CCIC_BIT_SEQ_ERR 7
`define CCIC_BIT_SEQ_CLR 6
`define CCIC_BIT_DLY_HI 4
`define CCIC_BIT_DLY_LO 3
`define CCIC_BIT_WR_BLOCK 2
`define CCIC_BIT_WD_FAST 1
`define CCIC_BIT_WD_OFF 0
`define CCIC_BIT_FREEZE 0
`define CCIC_BIT_ADDR_HI 7
`define CCIC_BIT_ADDR_LO 1
// -----------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------
`define CCIC_CLK_NS 4
`define CCIC_SDA_DLY_BASE_NS 250
`define CCIC_SDA_DLY_STEP_NS 50
`define CCIC_WD_LONG_NS 1000000000
`define CCIC_WD_SHORT_NS 50000
`define CCIC_RCV_HALF_NS 5000
`define CCIC_RCV_PULSES 9
`define CCIC_RCV_EDGES (2 * `CCIC_RCV_PULSES)
`endif

/* ccic_wdog.v */
// local bus watchdog: bus-free detection and nine-pulse scl recovery
`timescale 1ns/1ps
`default_nettype none
`include "ccic_map.vh"
module ccic_wdog #(
  parameter [31:0] WD_LONG_CYC = `CCIC_WD_LONG_NS / `CCIC_CLK_NS,
  parameter [31:0] WD_SHORT_CYC = `CCIC_WD_SHORT_NS / `CCIC_CLK_NS,
  parameter [31:0] RCV_HALF_CYC = `CCIC_RCV_HALF_NS / `CCIC_CLK_NS
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire wd_off,
  input wire wd_fast,
  // filtered bus levels and activity
  input wire sda_lvl,
  input wire bus_act,
  // results
  output reg bus_free_reg,
  output reg scl_low_reg,
  output wire recovering
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RCV = 1'b1;
  localparam [4:0] RCV_EDGES = `CCIC_RCV_EDGES;
  reg state_reg;
  reg [31:0] idle_cnt_reg;
  reg [31:0] half_cnt_reg;
  reg [4:0] edge_cnt_reg;
  wire [31:0] limit = wd_fast ? WD_SHORT_CYC : WD_LONG_CYC;
  wire expired = (idle_cnt_reg >= limit - 32'h1);
  // one half period of the recovery clock as an enable pulse
  wire half_tick = (half_cnt_reg == RCV_HALF_CYC - 32'h1);
  assign recovering = (state_reg == ST_RCV);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      idle_cnt_reg <= 32'h0;
      half_cnt_reg <= 32'h0;
      edge_cnt_reg <= 5'h0;
      bus_free_reg <= 1'b0;
      scl_low_reg <= 1'b0;
    end
    else if (wd_off)
    begin
      // a disabled watchdog neither frees nor recovers the bus
      state_reg <= ST_IDLE;
      idle_cnt_reg <= 32'h0;
      half_cnt_reg <= 32'h0;
      edge_cnt_reg <= 5'h0;
      bus_free_reg <= 1'b0;
      scl_low_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (bus_act)
          begin
            idle_cnt_reg <= 32'h0;
            bus_free_reg <= 1'b0;
          end
          else if (expired)
          begin
            idle_cnt_reg <= 32'h0;
            if (sda_lvl)
              bus_free_reg <= 1'b1;
            else
            begin
              state_reg <= ST_RCV;
              half_cnt_reg <= 32'h0;
              edge_cnt_reg <= 5'h0;
            end
          end
          else
            idle_cnt_reg <= idle_cnt_reg + 32'h1;
        end
        ST_RCV:
        begin
          // own scl toggling is not counted as bus activity
          half_cnt_reg <= half_tick ? 32'h0 : half_cnt_reg + 32'h1;
          if (half_tick)
          begin
            if (edge_cnt_reg == RCV_EDGES)
            begin
              state_reg <= ST_IDLE;
              scl_low_reg <= 1'b0;
            end
            else
            begin
              scl_low_reg <= ~edge_cnt_reg[0];
              edge_cnt_reg <= edge_cnt_reg + 5'h1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // ccic_wdog
`default_nettype wire
